// *** slave_port_pkg.sv ***
// constants, field layout and pin bundle for the slave port mailbox.
// assumes a single 40 MHz clock and an AXI4-Lite register bus on the core side.
package slave_port_pkg;
	localparam int unsigned NUM_DATA = 3;
	localparam int unsigned ADDR_W = 8;
	// core-side register byte offsets
	localparam logic [ADDR_W-1:0] OFF_DATA0 = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_DATA1 = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_DATA2 = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h0c;
	localparam logic [ADDR_W-1:0] OFF_INT_STATUS = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_INT_MASK = 8'h14;
	// master-side select value of the status register
	localparam logic [1:0] SEL_STATUS = 2'h3;
	// status register bit positions
	localparam int unsigned ST_M2S_FULL_LSB = 0;
	localparam int unsigned ST_S2M_FULL_LSB = 3;
	localparam int unsigned ST_M2S_ATTN = 6;
	localparam int unsigned ST_S2M_ATTN = 7;
	// interrupt status / mask bit positions
	localparam int unsigned INT_W = 3;
	localparam int unsigned INT_M2S_ZERO = 0;
	localparam int unsigned INT_ATTN_ACK = 1;
	localparam int unsigned INT_STATUS_WR = 2;
	// reset values
	localparam logic [7:0] DATA_RST = 8'h00;
	localparam logic [INT_W-1:0] INT_MASK_RST = 3'h0;
	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// master pins, sampled together through the synchroniser
	typedef struct packed {
		logic wr_n;
		logic rd_n;
		logic cs_n;
		logic [1:0] sel;
		logic [7:0] data;
	} master_pins_s;
endpackage

// *** slave_port_mailbox.sv ***
// slave port mailbox: three bytes each way between an external master and the core.
// assumes master pins are asynchronous to clk and strobes last several clk periods.
`timescale 1ns/1ps

// What this block does
// RQ1 - three master-to-slave and three slave-to-master byte registers, plus one status register
// RQ2 - master picks the register with two select lines, decoded here
// RQ3 - master writes master-to-slave registers, core reads them
// RQ4 - core writes slave-to-master registers, master reads them
// RQ5 - a read at a select returns the other direction's register, both sides
// RQ6 - master's write strobe latches its data byte into the selected register
// RQ7 - a master write to the status register is accepted too
// RQ8 - master read strobe drives selected slave-to-master register or status onto bus
// RQ9 - core write of register zero raises the attention line to the master
// RQ10 - master write of register zero raises a core interrupt when enabled
// RQ11 - only register zero accesses and master status writes raise attention or interrupts, never registers one, two
// RQ12 - status shows pending register-zero requests from either side
// RQ13 - each data register has a full flag set by the writing side
// RQ14 - the full flag clears when the receiving side reads that register
// RQ15 - a write sets full even when the byte is unchanged
// RQ16 - full and attention flag positions in status are fixed and documented
// RQ17 - the reader's access to register zero clears that side's pending request
module slave_port_mailbox (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [slave_port_pkg::ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [slave_port_pkg::ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire slave_port_pkg::master_pins_s m_pins,
	output logic [7:0] m_data_out,
	output logic m_data_oe_n,
	output logic m_attn,
	output logic irq
);
	import slave_port_pkg::*;

	// one-hot decode of a data register index, used for pins and bus
	function automatic logic [NUM_DATA-1:0] data_onehot(input logic [1:0] idx);
		logic [NUM_DATA-1:0] oh;
		oh = '0;
		case (idx)
			2'h0: oh = 3'h1;
			2'h1: oh = 3'h2;
			2'h2: oh = 3'h4;
			default: oh = 3'h0;
		endcase
		return oh;
	endfunction

	// bus address to data register index, 3 when not a data register
	function automatic logic [1:0] addr_idx(input logic [ADDR_W-1:0] a);
		logic [1:0] r;
		r = 2'h3;
		if (a == OFF_DATA0) r = 2'h0;
		else if (a == OFF_DATA1) r = 2'h1;
		else if (a == OFF_DATA2) r = 2'h2;
		return r;
	endfunction

	master_pins_s m_s1_q, m_s2_q, m_s3_q;
	logic [7:0] m2s_q [NUM_DATA];
	logic [7:0] s2m_q [NUM_DATA];
	logic [NUM_DATA-1:0] m2s_full_q, m2s_full_d, s2m_full_q, s2m_full_d;
	logic m2s_attn_q, m2s_attn_d, s2m_attn_q, s2m_attn_d;
	logic [INT_W-1:0] int_sts_q, int_sts_d, int_mask_q, int_mask_d;
	logic aw_hold_q, w_hold_q, awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
	logic [ADDR_W-1:0] aw_addr_q;
	logic [31:0] w_data_q, rdata_q;
	logic [3:0] w_strb_q;
	logic [1:0] bresp_q, rresp_q;
	logic [7:0] m_data_out_q;
	logic m_data_oe_n_q, m_attn_q, irq_q;

	// two-flop synchroniser, third stage for edge detection and for the strobed data, select and chip select
	always_ff @(posedge clk) begin
		m_s1_q <= m_pins;
		m_s2_q <= m_s1_q;
		m_s3_q <= m_s2_q;
	end

	// master strobe ends; data and select taken from the stage before the edge
	wire m_wr_ev = !m_s3_q.wr_n && m_s2_q.wr_n && !m_s3_q.cs_n; // see RQ6
	wire m_rd_ev = !m_s3_q.rd_n && m_s2_q.rd_n && !m_s3_q.cs_n;
	wire [NUM_DATA-1:0] m_wr_data = m_wr_ev ? data_onehot(m_s3_q.sel) : 3'h0; // see RQ2
	wire [NUM_DATA-1:0] m_rd_data = m_rd_ev ? data_onehot(m_s3_q.sel) : 3'h0;
	wire m_wr_status = m_wr_ev && (m_s3_q.sel == SEL_STATUS); // see RQ7
	wire m_rd_active = !m_s2_q.rd_n && !m_s2_q.cs_n; // see RQ8

	// bus handshakes
	wire aw_take = awvalid && awready_q;
	wire w_take = wvalid && wready_q;
	wire wr_fire = aw_hold_q && w_hold_q && !bvalid_q;
	wire aw_hold_d = (aw_hold_q || aw_take) && !wr_fire;
	wire w_hold_d = (w_hold_q || w_take) && !wr_fire;
	wire bvalid_d = wr_fire || (bvalid_q && !bready);
	wire ar_take = arvalid && arready_q;
	wire rvalid_d = ar_take || (rvalid_q && !rready);

	// core-side decode; only byte lane 0 carries data
	wire [1:0] w_idx = addr_idx(aw_addr_q);
	wire [1:0] r_idx = addr_idx(araddr);
	wire w_lane0 = w_strb_q[0];
	wire [NUM_DATA-1:0] sw_wr_data = (wr_fire && w_lane0) ? data_onehot(w_idx) : 3'h0; // see RQ4
	wire [NUM_DATA-1:0] sw_rd_data = ar_take ? data_onehot(r_idx) : 3'h0; // see RQ3
	wire sw_wr_mask = wr_fire && w_lane0 && (aw_addr_q == OFF_INT_MASK);
	wire sw_rd_int = ar_take && (araddr == OFF_INT_STATUS);
	wire w_mapped = (w_idx != 2'h3) || (aw_addr_q == OFF_INT_MASK) ||
		(aw_addr_q == OFF_STATUS) || (aw_addr_q == OFF_INT_STATUS);
	wire r_mapped = (r_idx != 2'h3) || (araddr == OFF_STATUS) ||
		(araddr == OFF_INT_STATUS) || (araddr == OFF_INT_MASK);

	// flags: a set in the same cycle as its clear wins, so no store is lost
	assign m2s_full_d = (m2s_full_q & ~sw_rd_data) | m_wr_data; // see RQ13 see RQ14 see RQ15
	assign s2m_full_d = (s2m_full_q & ~m_rd_data) | sw_wr_data; // see RQ13 see RQ14 see RQ15
	assign m2s_attn_d = (m2s_attn_q && !sw_rd_data[0]) || m_wr_data[0]; // see RQ10 see RQ17
	// master may also acknowledge attention by writing status with that bit set
	wire m_ack = m_rd_data[0] || (m_wr_status && m_s3_q.data[ST_S2M_ATTN]);
	assign s2m_attn_d = (s2m_attn_q && !m_ack) || sw_wr_data[0]; // see RQ9 see RQ11 see RQ17

	// status layout is fixed by package positions; core reads registered flags, master the next-state flags
	wire [7:0] status_w = {s2m_attn_q, m2s_attn_q, s2m_full_q, m2s_full_q}; // see RQ12 see RQ16
	wire [7:0] status_d = {s2m_attn_d, m2s_attn_d, s2m_full_d, m2s_full_d};

	// core interrupt: sticky events, cleared by reading int status, gated by mask
	wire [INT_W-1:0] int_ev = {m_wr_status, m_rd_data[0], m_wr_data[0]}; // see RQ10 see RQ11
	assign int_sts_d = (int_sts_q & ~{INT_W{sw_rd_int}}) | int_ev;
	assign int_mask_d = sw_wr_mask ? w_data_q[INT_W-1:0] : int_mask_q;

	// core read mux: data offsets return master-to-slave bytes
	wire [7:0] r_byte = (r_idx != 2'h3) ? m2s_q[r_idx] : // see RQ5
		(araddr == OFF_STATUS) ? status_w :
		(araddr == OFF_INT_STATUS) ? {5'h00, int_sts_q} :
		(araddr == OFF_INT_MASK) ? {5'h00, int_mask_q} : 8'h00;
	// master read mux: data selects return slave-to-master bytes
	wire [7:0] m_byte = (m_s2_q.sel == SEL_STATUS) ? status_d : s2m_q[m_s2_q.sel]; // see RQ5

	// data registers; master bytes come from the synchronised bus
	always_ff @(posedge clk) begin
		for (int i = 0; i < NUM_DATA; i++) begin
			if (!nrst) m2s_q[i] <= DATA_RST;
			else if (m_wr_data[i]) m2s_q[i] <= m_s3_q.data; // see RQ1 see RQ6
			if (!nrst) s2m_q[i] <= DATA_RST;
			else if (sw_wr_data[i]) s2m_q[i] <= w_data_q[7:0]; // see RQ1 see RQ4
		end
	end

	// flag state and interrupt registers
	always_ff @(posedge clk) begin
		if (!nrst) begin
			m2s_full_q <= 3'h0;
			s2m_full_q <= 3'h0;
			m2s_attn_q <= 1'b0;
			s2m_attn_q <= 1'b0;
			int_sts_q <= 3'h0;
			int_mask_q <= INT_MASK_RST;
			irq_q <= 1'b0;
			m_attn_q <= 1'b0;
		end else begin
			m2s_full_q <= m2s_full_d;
			s2m_full_q <= s2m_full_d;
			m2s_attn_q <= m2s_attn_d;
			s2m_attn_q <= s2m_attn_d;
			int_sts_q <= int_sts_d;
			int_mask_q <= int_mask_d;
			irq_q <= |(int_sts_d & int_mask_d);
			m_attn_q <= s2m_attn_d; // see RQ9
		end
	end

	// master data bus: driven while read strobe and chip select are low
	always_ff @(posedge clk) begin
		if (!nrst) begin
			m_data_out_q <= 8'h00;
			m_data_oe_n_q <= 1'b1;
		end else begin
			m_data_out_q <= m_byte; // see RQ8
			m_data_oe_n_q <= !m_rd_active;
		end
	end

	// write channel: address and data taken in either order
	always_ff @(posedge clk) begin
		if (!nrst) begin
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
			aw_addr_q <= '0;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
		end else begin
			aw_hold_q <= aw_hold_d;
			w_hold_q <= w_hold_d;
			awready_q <= !aw_hold_d;
			wready_q <= !w_hold_d;
			bvalid_q <= bvalid_d;
			if (aw_take) aw_addr_q <= awaddr;
			if (w_take) w_data_q <= wdata;
			if (w_take) w_strb_q <= wstrb;
			if (wr_fire) bresp_q <= w_mapped ? RESP_OKAY : RESP_SLVERR;
		end
	end

	// read channel: one read at a time, answer one cycle after address
	always_ff @(posedge clk) begin
		if (!nrst) begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= RESP_OKAY;
		end else begin
			arready_q <= !rvalid_d;
			rvalid_q <= rvalid_d;
			if (ar_take) rdata_q <= {24'h00_0000, r_byte};
			if (ar_take) rresp_q <= r_mapped ? RESP_OKAY : RESP_SLVERR;
		end
	end

	assign awready = awready_q;
	assign wready = wready_q;
	assign bvalid = bvalid_q;
	assign bresp = bresp_q;
	assign arready = arready_q;
	assign rvalid = rvalid_q;
	assign rdata = rdata_q;
	assign rresp = rresp_q;
	assign m_data_out = m_data_out_q;
	assign m_data_oe_n = m_data_oe_n_q;
	assign m_attn = m_attn_q;
	assign irq = irq_q;

	// checks on the mailbox behaviour
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	chk_attn_on_zero: assert property (sw_wr_data[0] |=> m_attn) // see RQ9
		else $error("attention not raised after core write of register zero");
	chk_irq_master_zero: assert property (m_wr_data[0] && int_mask_q[INT_M2S_ZERO] // see RQ10
		&& !sw_wr_mask |=> irq)
		else $error("core interrupt missing after master write of register zero");
	chk_attn_only_zero: assert property ($rose(m_attn) |-> $past(sw_wr_data[0])) // see RQ11
		else $error("attention rose without a register zero write");
	chk_full_on_write: assert property (m_wr_data[1] |=> m2s_full_q[1] && status_w[1]) // see RQ13
		else $error("full flag not set by master write");
	chk_full_on_read: assert property (sw_rd_data[2] && !m_wr_data[2] |=> !m2s_full_q[2]) // see RQ14
		else $error("full flag not cleared by core read");
	chk_attn_cleared: assert property (m_rd_data[0] && !sw_wr_data[0] |=> !m_attn) // see RQ17
		else $error("attention not cleared by master read of register zero");
	chk_master_read: assert property (m_rd_active && m_s2_q.sel == 2'h1 // see RQ5
		|=> !m_data_oe_n && m_data_out == $past(s2m_q[1]))
		else $error("master read did not drive slave-to-master register one");
	chk_core_read: assert property (sw_rd_data[0] |=> rvalid && rdata[7:0] == $past(m2s_q[0])) // see RQ3
		else $error("core read did not return master-to-slave register zero");
	chk_status_pend: assert property (m_wr_data[0] |=> status_w[ST_M2S_ATTN] && // see RQ12
		int_sts_q[INT_M2S_ZERO])
		else $error("status does not show master request pending");
	chk_bus_idle: assert property (!m_rd_active |=> m_data_oe_n) // see RQ8
		else $error("master bus driven without a read strobe");
	// the core-written direction, interrupt events, master bus drive and the bus answers
	chk_irq_only_zero: assert property ($rose(int_sts_q[INT_M2S_ZERO]) // see RQ11
		|-> $past(m_wr_data[0]))
		else $error("core interrupt event without a master register zero write");
	chk_s2m_full_set: assert property (sw_wr_data[1] |=> s2m_full_q[1]) // see RQ13
		else $error("full flag not set by core write");
	chk_s2m_full_clear: assert property (m_rd_data[1] && !sw_wr_data[1] // see RQ14
		|=> !s2m_full_q[1])
		else $error("full flag not cleared by master read");
	chk_status_write: assert property (m_wr_status |=> int_sts_q[INT_STATUS_WR]) // see RQ7
		else $error("master status write not recorded");
	chk_irq_level: assert property (irq == |(int_sts_q & int_mask_q)) // see RQ10
		else $error("interrupt line does not follow unmasked status");
	chk_core_write: assert property (sw_wr_data[1] // see RQ4
		|=> s2m_q[1] == $past(w_data_q[7:0]))
		else $error("core write did not store slave-to-master register one");
	chk_oe_on_read: assert property (m_rd_active |=> !m_data_oe_n) // see RQ8
		else $error("master bus not driven during a read strobe");
	chk_mask_write: assert property (sw_wr_mask
		|=> int_mask_q == $past(w_data_q[INT_W-1:0]))
		else $error("interrupt mask not stored");
	chk_bresp_unmapped: assert property (wr_fire && !w_mapped
		|=> bvalid && bresp == RESP_SLVERR)
		else $error("unmapped write not answered with an error");
	chk_read_answer: assert property (ar_take |=> rvalid && !arready)
		else $error("read answer not given one cycle after the address");

	cov_master_to_core: cover property (m_wr_data[0] ##[1:20] sw_rd_data[0]);
	cov_core_to_master: cover property (sw_wr_data[0] ##[1:20] m_rd_data[0]);
	cov_set_clear_same: cover property (m_wr_data[1] && sw_rd_data[1]);
	cov_status_ack: cover property (m_wr_status && s2m_attn_q);
endmodule

// *** master_model.sv ***
// model of the external master processor driving the slave port pins.
// assumes the bench calls its tasks from a process synchronised to clk.
`timescale 1ns/1ps
module master_model (
	input wire logic clk,
	input wire logic [7:0] dout,
	input wire logic oe_n,
	output slave_port_pkg::master_pins_s pins
);
	import slave_port_pkg::*;
	master_pins_s p_q;
	// byte bus: device byte while it drives, else ours (inverted once released)
	assign pins = {p_q[12:8], oe_n ? p_q.data : dout};
	initial p_q = '{1'b1, 1'b1, 1'b1, 2'h0, 8'h00};
	// strobe is held well past the synchroniser delay on both sides
	task automatic wr(input logic [1:0] s, input logic [7:0] d);
		@(posedge clk);
		p_q <= '{1'b1, 1'b1, 1'b0, s, d};
		repeat (5) @(posedge clk);
		p_q.wr_n <= 1'b0;
		repeat (5) @(posedge clk);
		p_q.wr_n <= 1'b1;
		repeat (6) @(posedge clk);
		p_q <= '{1'b1, 1'b1, 1'b1, s, ~d};
	endtask
	// read enable held until the driven byte has settled
	task automatic rd(input logic [1:0] s, output logic [7:0] d);
		@(posedge clk);
		p_q <= '{1'b1, 1'b0, 1'b0, s, ~p_q.data};
		repeat (8) @(posedge clk);
		d = pins.data;
		p_q.rd_n <= 1'b1;
		repeat (6) @(posedge clk);
		p_q.cs_n <= 1'b1;
	endtask
endmodule

// *** tb.sv ***
// self-checking bench for the slave port mailbox.
// assumes master_model stands in for the external master processor.
`timescale 1ns/1ps
module tb;
	import slave_port_pkg::*;
	logic clk, nrst, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid, m_data_oe_n, m_attn, irq;
	logic [7:0] awaddr, araddr, m_data_out, rb;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	master_pins_s m_pins;
	int n_fail, comparisons, cycles;
	slave_port_mailbox uut (.clk(clk), .nrst(nrst), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.m_pins(m_pins), .m_data_out(m_data_out), .m_data_oe_n(m_data_oe_n),
		.m_attn(m_attn), .irq(irq));
	master_model mst (.clk(clk), .dout(m_data_out), .oe_n(m_data_oe_n), .pins(m_pins));
	task automatic finish_test;
		$display("%0d comparisons, %0d mismatches", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// write address and data offered together, each released when taken
	task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
		logic aw_q, w_q;
		@(posedge clk);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		aw_q = 1'b1;
		w_q = 1'b1;
		while (aw_q || w_q) begin
			@(posedge clk);
			if (aw_q && awready) begin
				aw_q = 1'b0;
				awvalid <= 1'b0;
			end
			if (w_q && wready) begin
				w_q = 1'b0;
				wvalid <= 1'b0;
			end
		end
		do @(posedge clk); while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	task automatic wr_ok(input logic [7:0] a, input logic [7:0] d);
		logic [1:0] r;
		axi_wr(a, d, r);
		chk(32'(r), 32'(RESP_OKAY));
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		axi_rd(a, d, r);
		chk(32'(r), 32'(RESP_OKAY));
		chk(d, e);
	endtask
	// reset values and an unmapped address
	task automatic t_reset;
		logic [31:0] d;
		logic [1:0] r;
		chk(32'({irq, m_attn, m_data_oe_n}), 32'h1);
		rd_chk(OFF_INT_MASK, 32'(INT_MASK_RST));
		rd_chk(OFF_STATUS, 32'h0);
		axi_rd(8'h20, d, r);
		chk(32'(r), 32'(RESP_SLVERR));
		axi_wr(8'h20, 8'hff, r);
		chk(32'(r), 32'(RESP_SLVERR));
		$display("test reset done");
	endtask
	// master fills registers 1, 2 then 0; interrupt masked, then unmasked
	task automatic t_m2s;
		mst.wr(2'h1, 8'ha1);
		mst.wr(2'h2, 8'ha2);
		rd_chk(OFF_INT_STATUS, 32'h0);
		rd_chk(OFF_STATUS, 32'h06);
		mst.wr(2'h0, 8'ha0);
		chk(32'(irq), 32'h0);
		wr_ok(OFF_INT_MASK, 8'h01);
		chk(32'(irq), 32'h1);
		rd_chk(OFF_STATUS, 32'h47);
		rd_chk(OFF_DATA1, 32'ha1);
		rd_chk(OFF_DATA2, 32'ha2);
		rd_chk(OFF_DATA0, 32'ha0);
		rd_chk(OFF_STATUS, 32'h0);
		rd_chk(OFF_INT_STATUS, 32'h1);
		chk(32'(irq), 32'h0);
		$display("test master to slave done");
	endtask
	// core fills registers 1 and 0; master reads them back
	task automatic t_s2m;
		wr_ok(OFF_DATA1, 8'hb1);
		chk(32'(m_attn), 32'h0);
		wr_ok(OFF_DATA0, 8'hb0);
		chk(32'(m_attn), 32'h1);
		mst.rd(2'h1, rb);
		chk(32'(rb), 32'hb1);
		mst.rd(SEL_STATUS, rb);
		chk(32'(rb), 32'h88);
		mst.rd(2'h0, rb);
		chk(32'({rb, m_attn}), 32'h160);
		rd_chk(OFF_INT_STATUS, 32'h2);
		$display("test slave to master done");
	endtask
	// repeated equal store and a master write to the status register
	task automatic t_repeat;
		mst.wr(2'h2, 8'h55);
		rd_chk(OFF_DATA2, 32'h55);
		mst.wr(2'h2, 8'h55);
		rd_chk(OFF_STATUS, 32'h04);
		wr_ok(OFF_DATA0, 8'h3c);
		chk(32'(m_attn), 32'h1);
		mst.wr(SEL_STATUS, 8'h80);
		chk(32'(m_attn), 32'h0);
		rd_chk(OFF_INT_STATUS, 32'h4);
		// byte lane 0 off: answered, but register one must stay empty
		@(posedge clk);
		wstrb <= 4'h0;
		wr_ok(OFF_DATA1, 8'h77);
		wstrb <= 4'h1;
		rd_chk(OFF_STATUS, 32'h0c);
		$display("test repeat done");
	endtask
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// a hang is cut short well past the expected run of about 230 cycles
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 8000) begin
			n_fail++;
			finish_test();
		end
	end
	initial begin
		{nrst, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
		{awaddr, araddr, wdata} = 48'h0;
		wstrb = 4'h1;
		{n_fail, comparisons, cycles} = 96'h0;
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		t_reset();
		t_m2s();
		t_s2m();
		t_repeat();
		finish_test();
	end
endmodule
